/* File: src/sal_pkg.sv */
// constants and types shared by the speed/activity indicator block
// assumes a single 100 MHz chip clock and no software-visible registers
package sal_pkg;

    // clock period of the chip clock in ns
    localparam int unsigned CLK_PERIOD_NS     = 10;

    // half period of the activity blink, in ms
    localparam int unsigned BLINK_HALF_MS     = 100;

    // blink half period in clock cycles (rounded down, longest time)
    localparam int unsigned BLINK_HALF_CYCLES = (BLINK_HALF_MS * 1000000) / CLK_PERIOD_NS;

    // width of the blink counter, wide enough for the default count
    localparam int unsigned BLINK_CNT_W       = 24;

    // cycles spent in the strap phase after reset release: two sync stages plus one
    localparam int unsigned STRAP_CYCLES      = 3;

    // width of the strap wait counter
    localparam int unsigned STRAP_CNT_W       = 2;

    // position of the speed-select bit in the basic control register
    localparam int unsigned CTRL_SPEED_BIT    = 13;

    // position of the indicator mode field in the PHY control register
    localparam int unsigned MODE_FIELD_LSB    = 4;

    // value of the speed select after reset: 100 Mbps, as the pull-up gives
    localparam logic        SPEED_SEL_RST     = 1'b1;

    // level driven while the indicator is off or idle
    localparam logic        PIN_IDLE          = 1'b1;

    // reset value of the strap synchroniser, matching the board pull-up
    localparam logic        STRAP_SYNC_RST    = 1'b1;

    // indicator mode field encodings
    typedef enum logic [1:0] {
        SAL_MODE_SPEED = 2'h0,
        SAL_MODE_ACT   = 2'h1,
        SAL_MODE_RSV2  = 2'h2,
        SAL_MODE_RSV3  = 2'h3
    } sal_mode_t;

    // pin phase after reset, one-hot
    typedef enum logic [1:0] {
        SAL_ST_STRAP = 2'b01,
        SAL_ST_RUN   = 2'b10
    } sal_state_t;

endpackage

/* File: src/sal_sync.sv */
// two-flop synchroniser for one level coming from a pin
// assumes the destination clock is clk and the reset is asynchronous, active low
`timescale 1ns/1ps

module sal_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d_async,
    output logic      q_sync
);

    // first stage, read only by the second stage
    logic meta_reg;

    // both stages reset to a constant; the pin is only trusted after release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= RST_VAL;
            q_sync   <= RST_VAL;
        end
        else
        begin
            meta_reg <= d_async;
            q_sync   <= meta_reg;
        end
    end

endmodule

/* File: src/sal_top.sv */
// speed/activity status indicator pin with speed strap capture
// assumes link speed and activity come from transceiver logic on clk,
// and that the board holds the pin with a weak pull-up or strap resistor
`timescale 1ns/1ps

module sal_top
    import sal_pkg::*;
#(
    parameter int unsigned BLINK_CYCLES = sal_pkg::BLINK_HALF_CYCLES
) (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            status_indicator_b_in,
    output logic                 status_indicator_b_out,
    output logic                 status_indicator_b_oe,
    input  wire sal_pkg::sal_mode_t mode,
    input  wire logic            link_speed_10,
    input  wire logic            activity,
    output logic                 speed_sel_100,
    output logic                 adv_100
);

    // pin level after two flops
    logic                      strap_sync;
    // strap or run phase
    sal_state_t                state_reg;
    // cycles spent in the strap phase
    logic [STRAP_CNT_W-1:0]    strap_cnt_reg;
    // blink half-period counter
    logic [BLINK_CNT_W-1:0]    blink_cnt_reg;
    // one cycle at the end of each blink half period
    logic                      blink_tick;
    // activity seen since the last blink tick
    logic                      act_pend_reg;
    // run phase shorthand
    logic                      running;
    // past depth that lands on the last edge still held in reset
    localparam int unsigned    STRAP_PAST = STRAP_CYCLES + 1;

    assign running    = (state_reg == SAL_ST_RUN);
    assign blink_tick = running && (blink_cnt_reg == BLINK_CNT_W'(BLINK_CYCLES - 1));

    // pin synchronisation
    // the pin sits outside the clock domain, so it is resynchronised
    sal_sync #(
        .RST_VAL (STRAP_SYNC_RST)
    ) u_strap_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .d_async (status_indicator_b_in),
        .q_sync  (strap_sync)
    );

    // active-low reset
    // phase sequencing: stay in strap phase until the synchroniser holds
    // a level that was really sampled after release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg     <= SAL_ST_STRAP;
            strap_cnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                SAL_ST_STRAP:
                begin
                    // wait out the synchroniser depth
                    if (strap_cnt_reg == STRAP_CNT_W'(STRAP_CYCLES - 1))
                    begin
                        state_reg <= SAL_ST_RUN;
                    end
                    else
                    begin
                        strap_cnt_reg <= strap_cnt_reg + STRAP_CNT_W'(1);
                    end
                end
                SAL_ST_RUN:
                begin
                    // stays here until the next reset
                    state_reg <= SAL_ST_RUN;
                end
                default:
                begin
                    // illegal code recovers to the strap phase
                    state_reg <= SAL_ST_STRAP;
                end
            endcase
        end
    end

    // speed and advertisement
    // the captured level goes to both the speed select and the advertised
    // capability; a clocked capture avoids loading a pin under async reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            speed_sel_100 <= SPEED_SEL_RST;
            adv_100       <= SPEED_SEL_RST;
        end
        else if ((state_reg == SAL_ST_STRAP) && (strap_cnt_reg == STRAP_CNT_W'(STRAP_CYCLES - 1)))
        begin
            // high is 100 Mbps, low is 10 Mbps
            speed_sel_100 <= strap_sync;
            adv_100       <= strap_sync;
        end
    end

    // pin direction
    // pin is an input during reset and the strap phase, an output after
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_indicator_b_oe <= 1'b0;
        end
        else
        begin
            status_indicator_b_oe <= running;
        end
    end

    // blink timebase
    // free-running half-period counter, only counts once the run phase starts
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blink_cnt_reg <= '0;
        end
        else if (!running || blink_tick)
        begin
            blink_cnt_reg <= '0;
        end
        else
        begin
            blink_cnt_reg <= blink_cnt_reg + BLINK_CNT_W'(1);
        end
    end

    // activity stretch
    // short activity pulses are held until the next tick so they stay visible;
    // a new pulse in the tick cycle wins over the clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            act_pend_reg <= 1'b0;
        end
        else if (activity)
        begin
            act_pend_reg <= 1'b1;
        end
        else if (blink_tick)
        begin
            act_pend_reg <= 1'b0;
        end
    end

    // mode decode
    // pin level by mode; reserved codes leave the indicator off
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_indicator_b_out <= PIN_IDLE;
        end
        else if (!running)
        begin
            // not driven yet; keep the idle level ready
            status_indicator_b_out <= PIN_IDLE;
        end
        else
        begin
            case (mode)
                SAL_MODE_SPEED:
                begin
                    // high for 10 Mbps, low for 100 Mbps
                    status_indicator_b_out <= link_speed_10;
                end
                SAL_MODE_ACT:
                begin
                    // toggle or idle
                    // toggles once per tick while busy, back high when quiet;
                    // after a mode change it may take one half period to settle
                    if (blink_tick)
                    begin
                        status_indicator_b_out <= act_pend_reg ? ~status_indicator_b_out : PIN_IDLE;
                    end
                end
                default:
                begin
                    // reserved modes
                    status_indicator_b_out <= PIN_IDLE;
                end
            endcase
        end
    end

    property p_strap_capture;
        @(posedge clk) disable iff (!rst_n)
        $rose(running) |-> (speed_sel_100 == $past(strap_sync));
    endproperty
    a_strap_capture: assert property (p_strap_capture) else $error("speed select differs from strap");

    property p_mode_speed;
        @(posedge clk) disable iff (!rst_n)
        (running && (mode == SAL_MODE_SPEED)) |=> (status_indicator_b_out == $past(link_speed_10));
    endproperty
    a_mode_speed: assert property (p_mode_speed) else $error("speed mode pin level wrong");

    property p_mode_rsv;
        @(posedge clk) disable iff (!rst_n)
        (running && mode[1]) |=> status_indicator_b_out;
    endproperty
    a_mode_rsv: assert property (p_mode_rsv) else $error("reserved mode did not hold pin high");

    property p_strap_len;
        @(posedge clk) disable iff (!rst_n)
        $rose(running) |-> ($past(rst_n, STRAP_CYCLES) && !$past(rst_n, STRAP_PAST));
    endproperty
    a_strap_len: assert property (p_strap_len) else $error("strap phase too short after reset");

    property p_pin_dir;
        @(posedge clk) disable iff (!rst_n)
        (!running |-> !status_indicator_b_oe) and ($rose(running) |=> status_indicator_b_oe);
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("pin direction wrong for phase");

    property p_adv_match;
        @(posedge clk) disable iff (!rst_n)
        running |=> ($stable(speed_sel_100) && (adv_100 == speed_sel_100));
    endproperty
    a_adv_match: assert property (p_adv_match) else $error("advertised speed differs from select");

    property p_act_idle;
        @(posedge clk) disable iff (!rst_n)
        (blink_tick && !act_pend_reg && (mode == SAL_MODE_ACT)) |=> status_indicator_b_out;
    endproperty
    a_act_idle: assert property (p_act_idle) else $error("activity mode not high when idle");

    property p_act_steady;
        @(posedge clk) disable iff (!rst_n)
        (running && !blink_tick && (mode == SAL_MODE_ACT)) |=> $stable(status_indicator_b_out);
    endproperty
    a_act_steady: assert property (p_act_steady) else $error("activity pin changed between ticks");

endmodule

/* File: tb/sal_lamp.sv */
// board model: indicator lamp plus strap resistor on the shared pin
// assumes oe high means the block drives; otherwise the resistor sets the level
`timescale 1ns/1ps

module sal_lamp (
    input  wire logic drive,     // block's pin drive level
    input  wire logic oe,        // block's output enable
    input  wire logic strap_low, // fit a pull-down strap instead of the pull-up
    output logic      pin,       // resolved wire level
    output logic      lamp_on    // lamp lit when the pin sinks current
);
    // released pin falls back to the strap level, never to the last drive
    assign pin     = oe ? drive : ~strap_low;
    // lamp sits between supply and pin, so a low pin lights it
    assign lamp_on = ~pin;
endmodule

/* File: tb/sal_top_test.sv */
// self-checking bench for the speed/activity indicator block
// assumes a short blink period so that activity blinking fits the run
`timescale 1ns/1ps

module sal_top_test;
    import sal_pkg::*;
    localparam int unsigned BLINK = 8;  // short half period keeps the run small
    logic      clk;                     // 100 MHz clock
    logic      rst_n;                   // chip reset, active low
    logic      strap_low;               // board strap choice
    logic      pin;                     // resolved pin level
    logic      drv;                     // block drive level
    logic      oe;                      // block output enable
    logic      lamp;                    // lamp state
    sal_mode_t mode;                    // indicator mode field
    logic      spd10;                   // core reports 10 Mbps
    logic      act;                     // core activity
    logic      sel100;                  // speed select bit
    logic      adv100;                  // advertised 100 capability
    int        fail_count;              // mismatches
    int        n_tests;                 // comparisons made

    sal_top #(.BLINK_CYCLES(BLINK)) DUT (
        .clk(clk), .rst_n(rst_n), .status_indicator_b_in(pin), .status_indicator_b_out(drv),
        .status_indicator_b_oe(oe), .mode(mode), .link_speed_10(spd10), .activity(act),
        .speed_sel_100(sel100), .adv_100(adv100));
    sal_lamp board (.drive(drv), .oe(oe), .strap_low(strap_low), .pin(pin), .lamp_on(lamp));

    // clock generator
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // single-bit comparison
    task automatic chk(input logic got, input logic exp, input string msg);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // reset with a given strap, then follow the capture cycle by cycle
    task automatic t_strap(input logic low);
        @(posedge clk);
        rst_n     <= 1'b0;
        strap_low <= low;
        repeat (8) @(posedge clk);
        #1;
        chk(oe, 1'b0, "oe in reset");
        chk(sel100, SPEED_SEL_RST, "sel rst");
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(oe, 1'b0, "oe before capture");
        @(posedge clk);
        #1;
        chk(sel100, ~low, "speed select");
        chk(adv100, ~low, "advertised speed");
        @(posedge clk);
        #1;
        chk(oe, 1'b1, "oe after capture");
        $display("strap test done, low=%0b", low);
    endtask

    // speed mode and both reserved codes
    task automatic t_modes();
        @(posedge clk);
        mode  <= SAL_MODE_SPEED;
        spd10 <= 1'b1;
        @(posedge clk);
        #1;
        chk(drv, 1'b1, "10 Mbps level");
        chk(lamp, 1'b0, "lamp dark");
        @(posedge clk);
        spd10 <= 1'b0;
        @(posedge clk);
        #1;
        chk(drv, 1'b0, "100 Mbps level");
        chk(lamp, 1'b1, "lamp lit");
        @(posedge clk);
        mode <= SAL_MODE_RSV2;
        @(posedge clk);
        #1;
        chk(drv, 1'b1, "reserved 2 off");
        @(posedge clk);
        mode <= SAL_MODE_SPEED;
        @(posedge clk);
        #1;
        chk(drv, 1'b0, "back to speed");
        @(posedge clk);
        mode <= SAL_MODE_RSV3;
        @(posedge clk);
        #1;
        chk(drv, 1'b1, "reserved 3 off");
        $display("mode test done");
    endtask

    // steady activity blinks at the tick rate, then idles high
    task automatic t_blink();
        int   flips;
        int   lows;
        logic last;
        flips = 0;
        lows  = 0;
        @(posedge clk);
        mode <= SAL_MODE_ACT;
        act  <= 1'b1;
        #1;
        last = drv;
        for (int i = 0; i < 6 * BLINK; i++)
        begin
            @(posedge clk);
            #1;
            if (drv !== last)
                flips++;
            last = drv;
        end
        chk(flips >= 5 && flips <= 6, 1'b1, "blink count");
        @(posedge clk);
        act <= 1'b0;
        repeat (3 * BLINK) @(posedge clk);
        for (int i = 0; i < 2 * BLINK; i++)
        begin
            @(posedge clk);
            #1;
            if (drv !== 1'b1)
                lows++;
        end
        chk(lows == 0, 1'b1, "idle high");
        $display("blink test done");
    endtask

    // reset pulled low mid-run releases the pin at once
    task automatic t_midreset();
        @(posedge clk);
        mode  <= SAL_MODE_SPEED;
        spd10 <= 1'b0;
        @(posedge clk);
        #1;
        chk(drv, 1'b0, "drive low before reset");
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        chk(oe, 1'b0, "oe released");
        chk(drv, PIN_IDLE, "drive idle");
        chk(pin, 1'b1, "pin at pull level");
        $display("mid reset test done");
    endtask

    // watchdog against a hang
    initial
    begin
        #200000;
        fail_count++;
        results();
    end

    // main sequence
    initial
    begin
        fail_count = 0;
        n_tests    = 0;
        rst_n      = 1'b0;
        strap_low  = 1'b0;
        mode       = SAL_MODE_SPEED;
        spd10      = 1'b0;
        act        = 1'b0;
        t_strap(1'b0);
        t_modes();
        t_blink();
        t_midreset();
        t_strap(1'b1);
        results();
    end
endmodule
